// ---- host_model.sv ----
// host side of the serial link: chip select and output-drive phases
`timescale 1ns/1ns
module host_model (
	// clock
	input  wire logic       ref_clk,
	// phase: 0 idle, 1 selected quiet, 2 selected and driven
	input  wire logic [1:0] phase,
	// pins toward the device
	output logic            chip_select_n,
	output logic            sdoDriving
);
	// output driven only inside a frame, never while deselected
	always_ff @(posedge ref_clk) begin
		chip_select_n <= (phase == 2'h0);
		sdoDriving    <= (phase == 2'h2);
	end
endmodule

// ---- io_cfg_assertions.sv ----
// port assertions for the io configuration register bank
`timescale 1ns/1ns
module io_cfg_checker #(
	parameter int ADR_W   = 4,
	parameter int LEVEL_W = 8
) (
	// clock and reset
	input wire logic               ref_clk,
	input wire logic               reset,
	// wishbone
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [ADR_W-1:0]   wb_adr_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	// pins
	input wire logic               spiModeSel,
	input wire logic               txOn,
	input wire logic               tx_driver_a,
	input wire logic               tx_driver_b,
	input wire logic               rxInputBSel,
	input wire logic [LEVEL_W-1:0] txLevel,
	input wire logic               oscEnable,
	input wire logic               regulatorEnable,
	input wire logic               sdoPullDown,
	input wire logic               aatConvEnable,
	input wire logic               aatForceFixed,
	input wire logic [7:0]         aatOutA,
	input wire logic [7:0]         aatOutB
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence busReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence readFirst;
		busReq ##0 !wb_we_i && wb_adr_i == '0;
	endsequence
	sequence ackPulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	AST_ACK_ONE_CYCLE: assert property (busReq |=> ackPulse)
		else $error("ack not a single pulse one cycle after request");
	AST_RESERVED_ZERO: assert property (readFirst |=> wb_ack_o && !wb_dat_o[3])
		else $error("reserved bit read back as one");
	AST_DRIVER_ACTIVE: assert property (!$past(reset) |-> tx_driver_a || tx_driver_b)
		else $error("no antenna driver active");
	AST_RX_B_PAIR: assert property (rxInputBSel |-> tx_driver_b && !tx_driver_a)
		else $error("receive input b without driver b alone");
	AST_CONV_NEEDS_EN: assert property (aatConvEnable |-> oscEnable && !aatForceFixed)
		else $error("tuning converters on without device enable");
	AST_FIXED_VALUE: assert property (aatForceFixed |-> !oscEnable && aatOutA == 8'h80 && aatOutB == 8'h80)
		else $error("forced tuning value wrong");
	AST_ENABLE_PAIR: assert property (oscEnable == regulatorEnable)
		else $error("oscillator and regulator enables differ");
	AST_PD_SPI_ONLY: assert property (!spiModeSel [*4] |=> !sdoPullDown)
		else $error("pull-down active outside spi mode");
	AST_RAMP_OFF: assert property (!txOn |=> txLevel == '0)
		else $error("transmitter level not cleared after field off");
endmodule

// ---- io_cfg_pkg.sv ----
// shared constants for the io configuration register bank
package io_cfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [1:0] IDX_CFG_FIRST  = 2'h0;
	localparam logic [1:0] IDX_CFG_SECOND = 2'h1;
	localparam logic [1:0] IDX_OP_CTRL    = 2'h2;

	// reset values
	localparam logic [7:0] RST_CFG_FIRST  = 8'h00;
	localparam logic [7:0] RST_CFG_SECOND = 8'h00;
	localparam logic [7:0] RST_OP_CTRL    = 8'h00;

	// first configuration register fields
	localparam int BIT_SINGLE_DRIVE  = 7;
	localparam int BIT_DRIVER_B_SEL  = 6;
	localparam int BIT_HOLD_HI       = 5;
	localparam int BIT_HOLD_LO       = 4;
	localparam int BIT_RESERVED      = 3;
	localparam int BIT_CLK_SEL_HI    = 2;
	localparam int BIT_CLK_SEL_LO    = 1;
	localparam int BIT_LF_SUPPRESS   = 0;
	localparam logic [7:0] CFG_FIRST_WMASK = 8'hF7;

	// second configuration register fields
	localparam int BIT_LOW_SUPPLY    = 7;
	localparam int BIT_REG_DISABLE   = 6;
	localparam int BIT_AAT_ENABLE    = 5;
	localparam int BIT_PD_SELECTED   = 4;
	localparam int BIT_PD_DESELECTED = 3;
	localparam int BIT_DRIVE_LEVEL   = 2;
	localparam int BIT_MOD_REF_SEL   = 1;
	localparam int BIT_SLOW_RAMP     = 0;

	// operation control: only the device enable bit is held here
	localparam int BIT_DEV_ENABLE    = 7;
	localparam logic [7:0] OP_CTRL_WMASK = 8'h80;

	// host clock frequency codes
	localparam logic [1:0] CLK_SEL_3M39  = 2'h0;
	localparam logic [1:0] CLK_SEL_6M78  = 2'h1;
	localparam logic [1:0] CLK_SEL_13M56 = 2'h2;
	localparam logic [1:0] CLK_SEL_OFF   = 2'h3;

	// slow transmitter ramp timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int RAMP_MIN_NS    = 10000;
	localparam int RAMP_MIN_CYC   = (RAMP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_FULL      = 255;
	localparam int RAMP_SPAN      = (RAMP_FULL * 8 + 9) / 10;
	localparam int RAMP_STEP_CYC  = (RAMP_MIN_CYC + RAMP_SPAN - 1) / RAMP_SPAN;

	// ramp states
	typedef enum logic [2:0] {
		RAMP_IDLE = 3'b001,
		RAMP_RISE = 3'b010,
		RAMP_HOLD = 3'b100
	} ramp_state_e;

endpackage

// ---- io_configuration_regs.sv ----
// io configuration register bank with wishbone slave and pin control
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module io_configuration_regs #(
	parameter int ADR_W = 4,
	parameter int LEVEL_W = 8
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset,

	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,

	// asynchronous status pins
	input  wire logic                xtalRunning,
	input  wire logic                spiModeSel,
	input  wire logic                chip_select_n,

	// same-clock status from the host interface logic
	input  wire logic                sdoDriving,

	// clock sources for the host clock pin
	input  wire logic                xtalClk3m39,
	input  wire logic                xtalClk6m78,
	input  wire logic                xtalClk13m56,
	input  wire logic                lowFreqClk,

	// transmitter request and tuning values
	input  wire logic                txOn,
	input  wire logic [7:0]          aatValueA,
	input  wire logic [7:0]          aatValueB,

	// antenna drivers
	output logic                     tx_driver_a,
	output logic                     tx_driver_b,
	output logic                     rxInputBSel,
	output logic [LEVEL_W-1:0]       txLevel,
	output logic                     txRampDone,

	// host clock pin
	output logic                     hostClkOut,

	// power and regulators
	output logic                     oscEnable,
	output logic                     regulatorEnable,
	output logic                     low_supply_select,
	output logic                     digRegulatorOff,
	output logic                     mod_reg_reference_sel,

	// host interface pads
	output logic                     sdoPullDown,
	output logic                     ioDriveBoost,
	output logic [1:0]               holdTimeSel,

	// antenna tuning
	output logic                     aatConvEnable,
	output logic                     aatForceFixed,
	output logic [7:0]               aatOutA,
	output logic [7:0]               aatOutB
);

	// fixed tuning level; plain default, no figure available
	localparam logic [7:0] AAT_FIXED = 8'h80;

	// registers
	logic [7:0] cfgFirst;
	logic [7:0] cfgSecond;
	logic [7:0] opCtrl;
	logic       enSeenOnce;

	// synchronisers
	logic       xtalMeta;
	logic       xtalSync;
	logic       spiMeta;
	logic       spiSync;
	logic       csMeta;
	logic       csSync;

	// bus decode
	logic       busReq;
	logic       wrStrobe;
	logic [1:0] regIdx;
	logic       idxMapped;
	logic [7:0] readByte;

	// field views
	logic       singleDrive;
	logic       second_driver_select;
	logic [1:0] clkSel;
	logic       low_freq_clk_suppress;
	logic       aatEnable;
	logic       sdo_pulldown_selected;
	logic       sdo_pulldown_deselected;
	logic       slowRamp;
	logic       devEnable;

	// pin synchronisers: two flops before any logic
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			xtalMeta <= 1'b0;
			xtalSync <= 1'b0;
			spiMeta  <= 1'b0;
			spiSync  <= 1'b0;
			csMeta   <= 1'b1;
			csSync   <= 1'b1;
		end else begin
			xtalMeta <= xtalRunning;
			xtalSync <= xtalMeta;
			spiMeta  <= spiModeSel;
			spiSync  <= spiMeta;
			csMeta   <= chip_select_n;
			csSync   <= csMeta;
		end
	end

	// wishbone decode; only byte lane 0 carries data
	assign busReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wrStrobe  = busReq && wb_we_i && wb_sel_i[0];
	assign regIdx    = wb_adr_i[3:2];
	assign idxMapped = (wb_adr_i[1:0] == 2'h0) && ((wb_adr_i >> 4) == '0);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			// unmapped addresses are acked too
			wb_ack_o <= busReq;
		end
	end

	// first configuration register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfgFirst <= io_cfg_pkg::RST_CFG_FIRST;
		end else if (wrStrobe && idxMapped && regIdx == io_cfg_pkg::IDX_CFG_FIRST) begin
			cfgFirst <= wb_dat_i[7:0] & io_cfg_pkg::CFG_FIRST_WMASK;
		end
	end

	// second configuration register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfgSecond <= io_cfg_pkg::RST_CFG_SECOND;
		end else if (wrStrobe && idxMapped && regIdx == io_cfg_pkg::IDX_CFG_SECOND) begin
			cfgSecond <= wb_dat_i[7:0];
		end
	end

	// operation control, device enable only
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opCtrl <= io_cfg_pkg::RST_OP_CTRL;
		end else if (wrStrobe && idxMapped && regIdx == io_cfg_pkg::IDX_OP_CTRL) begin
			opCtrl <= wb_dat_i[7:0] & io_cfg_pkg::OP_CTRL_WMASK;
		end
	end

	// remembers that the device was enabled since reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enSeenOnce <= 1'b0;
		end else if (devEnable) begin
			enSeenOnce <= 1'b1;
		end
	end

	// read mux
	always_comb begin
		readByte = 8'h00;
		if (!idxMapped) begin
			readByte = 8'h00;
		end else if (regIdx == io_cfg_pkg::IDX_CFG_FIRST) begin
			readByte = cfgFirst & io_cfg_pkg::CFG_FIRST_WMASK;
		end else if (regIdx == io_cfg_pkg::IDX_CFG_SECOND) begin
			readByte = cfgSecond;
		end else if (regIdx == io_cfg_pkg::IDX_OP_CTRL) begin
			readByte = opCtrl;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (busReq && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, readByte};
		end
	end

	// field views
	assign singleDrive             = cfgFirst[io_cfg_pkg::BIT_SINGLE_DRIVE];
	assign second_driver_select    = cfgFirst[io_cfg_pkg::BIT_DRIVER_B_SEL];
	assign clkSel                  = {cfgFirst[io_cfg_pkg::BIT_CLK_SEL_HI], cfgFirst[io_cfg_pkg::BIT_CLK_SEL_LO]};
	assign low_freq_clk_suppress   = cfgFirst[io_cfg_pkg::BIT_LF_SUPPRESS];
	assign aatEnable               = cfgSecond[io_cfg_pkg::BIT_AAT_ENABLE];
	assign sdo_pulldown_selected   = cfgSecond[io_cfg_pkg::BIT_PD_SELECTED];
	assign sdo_pulldown_deselected = cfgSecond[io_cfg_pkg::BIT_PD_DESELECTED];
	assign slowRamp                = cfgSecond[io_cfg_pkg::BIT_SLOW_RAMP];
	assign devEnable               = opCtrl[io_cfg_pkg::BIT_DEV_ENABLE];

	// antenna driver selection
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_driver_a <= 1'b0;
			tx_driver_b <= 1'b0;
			rxInputBSel <= 1'b0;
		end else begin
			tx_driver_a <= !singleDrive || !second_driver_select;
			tx_driver_b <= !singleDrive || second_driver_select;
			rxInputBSel <= singleDrive && second_driver_select;
		end
	end

	// host clock pin routing; a clock mux, so sources are not resampled
	always_comb begin
		hostClkOut = 1'b0;
		if (clkSel == io_cfg_pkg::CLK_SEL_OFF) begin
			hostClkOut = 1'b0;
		end else if (xtalSync) begin
			case (clkSel)
				io_cfg_pkg::CLK_SEL_3M39:  hostClkOut = xtalClk3m39;
				io_cfg_pkg::CLK_SEL_6M78:  hostClkOut = xtalClk6m78;
				io_cfg_pkg::CLK_SEL_13M56: hostClkOut = xtalClk13m56;
				default:                   hostClkOut = 1'b0;
			endcase
		end else if (!low_freq_clk_suppress) begin
			hostClkOut = lowFreqClk;
		end
	end

	// power and regulator controls
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			oscEnable             <= 1'b0;
			regulatorEnable       <= 1'b0;
			low_supply_select     <= 1'b0;
			digRegulatorOff       <= 1'b0;
			mod_reg_reference_sel <= 1'b0;
		end else begin
			oscEnable             <= devEnable;
			regulatorEnable       <= devEnable;
			low_supply_select     <= cfgSecond[io_cfg_pkg::BIT_LOW_SUPPLY];
			digRegulatorOff       <= cfgSecond[io_cfg_pkg::BIT_REG_DISABLE];
			mod_reg_reference_sel <= cfgSecond[io_cfg_pkg::BIT_MOD_REF_SEL];
		end
	end

	// host interface pad controls
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sdoPullDown  <= 1'b0;
			ioDriveBoost <= 1'b0;
			holdTimeSel  <= 2'h0;
		end else begin
			sdoPullDown  <= spiSync &&
				((sdo_pulldown_selected && !csSync && !sdoDriving) ||
				 (sdo_pulldown_deselected && csSync));
			ioDriveBoost <= cfgSecond[io_cfg_pkg::BIT_DRIVE_LEVEL];
			holdTimeSel  <= {cfgFirst[io_cfg_pkg::BIT_HOLD_HI], cfgFirst[io_cfg_pkg::BIT_HOLD_LO]};
		end
	end

	// antenna tuning converters
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aatConvEnable <= 1'b0;
			aatForceFixed <= 1'b0;
			aatOutA       <= 8'h00;
			aatOutB       <= 8'h00;
		end else begin
			aatConvEnable <= aatEnable && devEnable;
			aatForceFixed <= aatEnable && !devEnable && enSeenOnce;
			if (aatEnable && devEnable) begin
				aatOutA <= aatValueA;
				aatOutB <= aatValueB;
			end else if (aatEnable && enSeenOnce) begin
				aatOutA <= AAT_FIXED;
				aatOutB <= AAT_FIXED;
			end else begin
				aatOutA <= 8'h00;
				aatOutB <= 8'h00;
			end
		end
	end

	// transmitter ramp
	// slow ramp control
	tx_ramp #(
		.LEVEL_W  (LEVEL_W),
		.STEP_CYC (io_cfg_pkg::RAMP_STEP_CYC)
	) u_ramp (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.txOn      (txOn),
		.slowRamp  (slowRamp),
		.rampLevel (txLevel),
		.rampDone  (txRampDone)
	);

endmodule

// ---- testbench.sv ----
// self-checking bench for the io configuration register bank
`timescale 1ns/1ns
module testbench;
	logic        ref_clk = 1'h0, reset = 1'h1;
	logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic        wb_ack_o, xtalRunning = 1'h1, spiModeSel = 1'h0, chip_select_n, sdoDriving;
	logic        xtalClk3m39 = 1'h0, xtalClk6m78 = 1'h0, xtalClk13m56 = 1'h0, lowFreqClk = 1'h0;
	logic        txOn = 1'h0, tx_driver_a, tx_driver_b, rxInputBSel, txRampDone, hostClkOut;
	logic        oscEnable, regulatorEnable, low_supply_select, digRegulatorOff, mod_reg_reference_sel;
	logic        sdoPullDown, ioDriveBoost, aatConvEnable, aatForceFixed;
	logic [1:0]  holdTimeSel, phase = 2'h0;
	logic [7:0]  aatValueA = 8'h00, aatValueB = 8'h00, txLevel, aatOutA, aatOutB, q, d;
	logic [3:0]  taps, selMask = 4'hF;
	logic [8:0]  clkCase [7] = '{9'h100, 9'h102, 9'h104, 9'h106, 9'h000, 9'h001, 9'h006};
	int          mismatches = 0, tests_run = 0, n, k;

	initial forever #20 ref_clk = ~ref_clk;

	io_configuration_regs u_io_configuration_regs (.*);
	host_model u_host_model (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one classic cycle; waits for ack, never assumes its delay
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		int t;
		t = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_sel_i <= selMask;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, v};
		do begin
			@(posedge ref_clk);
			t++;
		end while (wb_ack_o !== 1'h1 && t < 20);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (t >= 20) begin
			mismatches++;
			end_of_test();
		end
	endtask

	task automatic settle();
		repeat (6) @(posedge ref_clk);
	endtask

	function automatic logic expClk(logic [8:0] c, logic [3:0] t);
		if (c[2:1] == 2'h3) return 1'h0;
		if (c[8]) return t[c[2:1]];
		return c[0] ? 1'h0 : t[3];
	endfunction

	initial begin
		void'($urandom(32'h6583_c18f));
		repeat (4) @(posedge ref_clk);
		reset <= 1'h0;
		for (int i = 0; i < 3; i++) begin
			bus(1'h0, 4'(4 * i), 8'h00);
			chk(q, 32'h0000_0000);
		end
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			bus(1'h1, 4'h0, d);
			bus(1'h1, 4'h4, d);
			bus(1'h1, 4'hC, d);
			bus(1'h0, 4'h0, 8'h00);
			chk(q, d & 8'hF7);
			bus(1'h0, 4'h4, 8'h00);
			chk(q, d);
			bus(1'h0, 4'hC, 8'h00);
			chk(q, 32'h0000_0000);
			settle();
			chk(ioDriveBoost, d[2]);
			chk(mod_reg_reference_sel, d[1]);
			chk({low_supply_select, digRegulatorOff, holdTimeSel}, {d[7:6], d[5:4]});
		end
		selMask = 4'hE;
		bus(1'h1, 4'h4, ~d);
		selMask = 4'hF;
		bus(1'h0, 4'h4, 8'h00);
		chk(q, d);
		$display("test registers done");
		foreach (clkCase[i]) begin
			d = clkCase[i][7:0] | 8'hC0;
			bus(1'h1, 4'h0, d);
			xtalRunning <= clkCase[i][8];
			settle();
			chk({tx_driver_a, tx_driver_b, rxInputBSel}, 3'h3);
			for (int j = 0; j < 6; j++) begin
				@(posedge ref_clk);
				{lowFreqClk, xtalClk13m56, xtalClk6m78, xtalClk3m39} <= 4'($urandom);
				@(negedge ref_clk);
				taps = {lowFreqClk, xtalClk13m56, xtalClk6m78, xtalClk3m39};
				chk(hostClkOut, expClk(clkCase[i], taps));
			end
		end
		xtalRunning <= 1'h1;
		for (int i = 0; i < 2; i++) begin
			bus(1'h1, 4'h0, i ? 8'h80 : 8'h00);
			settle();
			chk({tx_driver_a, tx_driver_b, rxInputBSel}, {1'h1, ~i[0], 1'h0});
		end
		$display("test drivers and host clock done");
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				bus(1'h1, 4'h4, {3'h0, 2'(p), 3'h0});
				for (int h = 0; h < 3; h++) begin
					spiModeSel <= s[0];
					phase <= 2'(h);
					settle();
					chk(sdoPullDown, s[0] && (h == 0 ? p[0] : (h == 1 && p[1])));
				end
			end
		end
		phase <= 2'h0;
		$display("test pull-downs done");
		bus(1'h1, 4'h4, 8'h20);
		aatValueA <= 8'($urandom);
		aatValueB <= 8'($urandom);
		// enable set before it is cleared
		bus(1'h1, 4'h8, 8'hFF);
		bus(1'h0, 4'h8, 8'h00);
		chk(q, 8'h80);
		settle();
		chk({oscEnable, regulatorEnable, aatConvEnable}, 3'h7);
		chk({aatOutA, aatOutB}, {aatValueA, aatValueB});
		bus(1'h1, 4'h8, 8'h00);
		settle();
		chk({aatForceFixed, aatConvEnable, aatOutA}, {2'h2, 8'h80});
		$display("test tuning done");
		bus(1'h1, 4'h4, 8'h00);
		txOn <= 1'h1;
		settle();
		chk(txLevel, 8'hFF);
		txOn <= 1'h0;
		bus(1'h1, 4'h4, 8'h01);
		txOn <= 1'h1;
		n = 0;
		k = 0;
		while (txLevel !== 8'hFF && k < 3000) begin
			@(posedge ref_clk);
			k++;
			if (txLevel >= 8'd26 && txLevel < 8'd230) n++;
		end
		chk(n >= 250 && k < 3000, 1'h1);
		@(posedge ref_clk);
		chk(txRampDone, 1'h1);
		txOn <= 1'h0;
		$display("test ramp done");
		end_of_test();
	end
endmodule

bind io_configuration_regs io_cfg_checker #(.ADR_W(ADR_W), .LEVEL_W(LEVEL_W)) u_io_cfg_checker (.*);

// ---- tx_ramp.sv ----
// transmitter amplitude ramp generator
`timescale 1ns/1ns
module tx_ramp #(
	parameter int LEVEL_W = 8,
	parameter int STEP_CYC = io_cfg_pkg::RAMP_STEP_CYC
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               reset,
	// control
	input  wire logic               txOn,
	input  wire logic               slowRamp,
	// amplitude
	output logic [LEVEL_W-1:0]      rampLevel,
	output logic                    rampDone
);

	localparam logic [LEVEL_W-1:0] LEVEL_MAX = {LEVEL_W{1'b1}};
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

	io_cfg_pkg::ramp_state_e state;
	logic [15:0]             stepCount;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= io_cfg_pkg::RAMP_IDLE;
		end else if (!txOn) begin
			state <= io_cfg_pkg::RAMP_IDLE;
		end else begin
			case (state)
				io_cfg_pkg::RAMP_IDLE: begin
					state <= slowRamp ? io_cfg_pkg::RAMP_RISE : io_cfg_pkg::RAMP_HOLD;
				end
				io_cfg_pkg::RAMP_RISE: begin
					if (rampLevel == LEVEL_MAX) begin
						state <= io_cfg_pkg::RAMP_HOLD;
					end
				end
				default: begin
					state <= io_cfg_pkg::RAMP_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || state != io_cfg_pkg::RAMP_RISE) begin
			stepCount <= '0;
		end else if (stepCount == STEP_LAST) begin
			stepCount <= '0;
		end else begin
			stepCount <= stepCount + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !txOn) begin
			rampLevel <= '0;
		end else if (state == io_cfg_pkg::RAMP_HOLD) begin
			rampLevel <= LEVEL_MAX;
		end else if (state == io_cfg_pkg::RAMP_RISE && stepCount == STEP_LAST && rampLevel != LEVEL_MAX) begin
			rampLevel <= rampLevel + {{(LEVEL_W-1){1'b0}}, 1'b1};
		end
	end

	assign rampDone = (state == io_cfg_pkg::RAMP_HOLD) && (rampLevel == LEVEL_MAX);

endmodule
